// >>> hdl/mfos_defs.svh
// Constants for the multifunction output selector.
`ifndef MFOS_DEFS_SVH
`define MFOS_DEFS_SVH
// ------------------------------------------------------------------
// Frequencies in 0.01 Hz steps
// ------------------------------------------------------------------
`define MFOS_FREQ_MAX 16'h9c40
`define MFOS_LEVEL_DEF 16'h0bb8
`define MFOS_BW_DEF 16'h03e8
// ------------------------------------------------------------------
// Function codes and fault mask bits
// ------------------------------------------------------------------
`define MFOS_CODE_MAX 5'h13
`define MFOS_OC_CODE_DEF 5'h0c
`define MFOS_RELAY_CODE_DEF 5'h11
`define MFOS_MASK_UV 0
`define MFOS_MASK_TRIP 1
`define MFOS_MASK_RESTART 2
`define MFOS_ROUTE_OC 0
`define MFOS_ROUTE_RELAY 1
// ------------------------------------------------------------------
// DC link trip thresholds in volts
// ------------------------------------------------------------------
`define MFOS_OV_200 10'h190
`define MFOS_OV_400 10'h334
`define MFOS_UV_200 10'h0b4
`define MFOS_UV_400 10'h168
// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define MFOS_CLK_PS 8000
`define MFOS_SAMPLE_NS 1000
`define MFOS_SAMPLE_CYC ((`MFOS_SAMPLE_NS * 1000 + `MFOS_CLK_PS - 1) / `MFOS_CLK_PS)
`define MFOS_MS_US 1000
`define MFOS_MS_CYC ((`MFOS_MS_US * 1000000) / `MFOS_CLK_PS)
`define MFOS_KEYPAD_TIMEOUT_MS 2000
`endif

// >>> hdl/mfos_pkg.sv
// Types shared by the multifunction output selector.
package mfos_pkg;
    typedef enum logic [4:0] {
        FN_MATCH = 5'h00, FN_MATCH_LVL = 5'h01, FN_WINDOW = 5'h02,
        FN_HYST = 5'h03, FN_HYST_INV = 5'h04, FN_MOTOR_OL = 5'h05,
        FN_DRIVE_OL = 5'h06, FN_STALL = 5'h07, FN_OV = 5'h08,
        FN_UV = 5'h09, FN_OVERHEAT = 5'h0a, FN_CMD_LOSS = 5'h0b,
        FN_RUN = 5'h0c, FN_STOP = 5'h0d, FN_CONST = 5'h0e,
        FN_SEARCH = 5'h0f, FN_WAIT_RUN = 5'h10, FN_FAULT = 5'h11,
        FN_FAN = 5'h12, FN_BRAKE = 5'h13
    } mfos_func_t;
    typedef enum logic [0:0] {
        HYST_OFF = 1'b0,
        HYST_ON = 1'b1
    } mfos_hyst_t;
endpackage

// >>> hdl/mfos_freq_if.sv
// Carrier between the selector and its frequency detector.
`timescale 1ns/1ps
`default_nettype none
interface mfos_freq_if;
    logic [15:0] freq_cmd;
    logic [15:0] freq_run;
    logic [15:0] level;
    logic [15:0] bandwidth;
    logic accel;
    logic decel;
    logic sample_en;
    logic match;
    logic match_at_level;
    logic window;
    logic hyst;
    logic hyst_inv;
    modport det(input freq_cmd, freq_run, level, bandwidth, accel, decel, sample_en,
        output match, match_at_level, window, hyst, hyst_inv);
    modport user(output freq_cmd, freq_run, level, bandwidth, accel, decel, sample_en,
        input match, match_at_level, window, hyst, hyst_inv);
endinterface
`default_nettype wire

// >>> hdl/mfos_freq_detect.sv
// Frequency comparisons for the five detection codes.
`timescale 1ns/1ps
`default_nettype none
module mfos_freq_detect (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Detector side of the carrier.
    mfos_freq_if.det fif
);
    logic [15:0] half_bw;
    logic [15:0] diff_cmd;
    logic [15:0] diff_lvl;
    logic [15:0] low_edge;
    mfos_pkg::mfos_hyst_t hyst_reg;
    mfos_pkg::mfos_hyst_t hyst_next;

    // Distances and the lower hysteresis edge, floored at zero.
    assign half_bw = fif.bandwidth >> 1;
    assign diff_cmd = (fif.freq_cmd > fif.freq_run) ? fif.freq_cmd - fif.freq_run
                                                   : fif.freq_run - fif.freq_cmd;
    assign diff_lvl = (fif.level > fif.freq_run) ? fif.level - fif.freq_run
                                                : fif.freq_run - fif.level;
    assign low_edge = (fif.level > half_bw) ? fif.level - half_bw : 16'h0000;

    // Window comparisons.
    assign fif.match = (diff_cmd <= half_bw);
    assign fif.match_at_level = fif.match && (fif.freq_cmd == fif.level);
    assign fif.window = (diff_lvl <= half_bw);

    // Hysteresis: set at level when speeding up, kept above low edge when slowing.
    always_comb begin
        hyst_next = hyst_reg;
        if (fif.accel) begin
            hyst_next = (fif.freq_run >= fif.level) ? mfos_pkg::HYST_ON : mfos_pkg::HYST_OFF;
        end else if (fif.decel) begin
            hyst_next = (fif.freq_run > low_edge) ? mfos_pkg::HYST_ON : mfos_pkg::HYST_OFF;
        end
    end

    // The detector state moves only on the control sample.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hyst_reg <= mfos_pkg::HYST_OFF;
        end else if (fif.sample_en) begin
            hyst_reg <= hyst_next;
        end
    end

    assign fif.hyst = (hyst_reg == mfos_pkg::HYST_ON);
    assign fif.hyst_inv = !fif.hyst;

    sequence s_accel_at_level;
        fif.sample_en && fif.accel && (fif.freq_run >= fif.level);
    endsequence
    sequence s_decel_below;
        fif.sample_en && !fif.accel && fif.decel && (fif.freq_run <= low_edge);
    endsequence

    AST_HYST_ACCEL: assert property (@(posedge clk) disable iff (!rst_b)
        s_accel_at_level |=> fif.hyst)
        else $error("Hysteresis detector missed the level while accelerating.");
    AST_HYST_DECEL: assert property (@(posedge clk) disable iff (!rst_b)
        s_decel_below |=> !fif.hyst && fif.hyst_inv)
        else $error("Hysteresis detector held below the low edge while decelerating.");
    AST_MATCH_LVL: assert property (@(posedge clk) disable iff (!rst_b)
        fif.match_at_level |-> fif.window && (fif.freq_cmd == fif.level))
        else $error("Level match asserted without both conditions.");
endmodule // mfos_freq_detect
`default_nettype wire

// >>> hdl/mfos_top.sv
// Multifunction output selector: open collector and relay status outputs.
`timescale 1ns/1ps
`default_nettype none
`include "mfos_defs.svh"
module mfos_top #(
    parameter int MS_TICK_CYCLES = `MFOS_MS_CYC,
    parameter int KEYPAD_TIMEOUT_MS = `MFOS_KEYPAD_TIMEOUT_MS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Frequencies, 0.01 Hz per step.
    input wire logic [15:0] freq_cmd,
    input wire logic [15:0] freq_run,
    input wire logic [15:0] freq_detect_level,
    input wire logic [15:0] freq_detect_bandwidth,
    input wire logic [15:0] max_frequency_limit,
    // Output selection settings.
    input wire logic [4:0] open_collector_function_code,
    input wire logic [4:0] relay_function_code,
    input wire logic [2:0] fault_condition_mask,
    input wire logic [1:0] keypad_error_routing,
    input wire logic [1:0] fan_trip_handling,
    input wire logic brake_enable,
    // Motion state.
    input wire logic run_cmd,
    input wire logic output_active,
    input wire logic accel,
    input wire logic decel,
    input wire logic run_wait,
    // Supply.
    input wire logic [9:0] dc_link_volts,
    input wire logic class_400v,
    // Status from the protection units.
    input wire logic motor_overload_flag,
    input wire logic drive_overload_flag,
    input wire logic stall_flag,
    input wire logic speed_search_flag,
    input wire logic heatsink_overheat_flag,
    input wire logic analog_ref_lost,
    input wire logic rs485_cmd_lost,
    input wire logic other_trip,
    input wire logic restart_exhausted,
    input wire logic fan_trip_alarm,
    input wire logic brake_signal,
    // Keypad serial link health.
    input wire logic keypad_link_ok,
    // Results.
    output logic open_collector_output,
    output logic open_collector_pin_out,
    output logic open_collector_pin_oe_b,
    output logic relay_contact_output,
    output logic keypad_comm_error,
    output logic ov_trip,
    output logic uv_trip,
    output logic [15:0] level_applied,
    output logic [15:0] bandwidth_applied
);
    localparam int SAMPLE_CYC = `MFOS_SAMPLE_CYC;

    // ------------------------------------------------------------------
    // Rate dividers
    // ------------------------------------------------------------------
    logic [7:0] sample_cnt_reg;
    logic [16:0] ms_cnt_reg;
    logic sample_tick;
    logic ms_tick;

    // Control sample enable.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sample_cnt_reg <= 8'h00;
        end else if (sample_cnt_reg == 8'(SAMPLE_CYC - 1)) begin
            sample_cnt_reg <= 8'h00;
        end else begin
            sample_cnt_reg <= sample_cnt_reg + 8'h01;
        end
    end
    assign sample_tick = (sample_cnt_reg == 8'(SAMPLE_CYC - 1));

    // Millisecond enable for the keypad timeout.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ms_cnt_reg <= 17'h00000;
        end else if (ms_cnt_reg == 17'(MS_TICK_CYCLES - 1)) begin
            ms_cnt_reg <= 17'h00000;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 17'h00001;
        end
    end
    assign ms_tick = (ms_cnt_reg == 17'(MS_TICK_CYCLES - 1));

    // ------------------------------------------------------------------
    // Setting limits
    // ------------------------------------------------------------------
    logic [15:0] freq_ceiling;

    // Limit a setting to the lower of the maximum frequency and 400 Hz.
    function automatic logic [15:0] clamp_freq(input logic [15:0] v, input logic [15:0] lim);
        return (v > lim) ? lim : v;
    endfunction

    assign freq_ceiling = (max_frequency_limit > `MFOS_FREQ_MAX) ? `MFOS_FREQ_MAX
                                                                : max_frequency_limit;

    // Applied settings are held in registers so a comparison sees a steady value.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level_applied <= `MFOS_LEVEL_DEF;
            bandwidth_applied <= `MFOS_BW_DEF;
        end else begin
            level_applied <= clamp_freq(freq_detect_level, freq_ceiling);
            bandwidth_applied <= clamp_freq(freq_detect_bandwidth, freq_ceiling);
        end
    end

    // ------------------------------------------------------------------
    // Frequency detection
    // ------------------------------------------------------------------
    mfos_freq_if fif();

    assign fif.freq_cmd = freq_cmd;
    assign fif.freq_run = freq_run;
    assign fif.level = level_applied;
    assign fif.bandwidth = bandwidth_applied;
    assign fif.accel = accel;
    assign fif.decel = decel;
    assign fif.sample_en = sample_tick;

    mfos_freq_detect u_detect (
        .clk(clk),
        .rst_b(rst_b),
        .fif(fif)
    );

    // ------------------------------------------------------------------
    // DC link trips
    // ------------------------------------------------------------------
    logic ov_now;
    logic uv_now;

    // Thresholds depend on the voltage class.
    assign ov_now = class_400v ? (dc_link_volts > `MFOS_OV_400)
                               : (dc_link_volts > `MFOS_OV_200);
    assign uv_now = class_400v ? (dc_link_volts < `MFOS_UV_400)
                               : (dc_link_volts < `MFOS_UV_200);

    // Trip flags follow the comparison with one cycle of delay.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ov_trip <= 1'b0;
            uv_trip <= 1'b0;
        end else begin
            ov_trip <= ov_now;
            uv_trip <= uv_now;
        end
    end

    // ------------------------------------------------------------------
    // Keypad link watchdog
    // ------------------------------------------------------------------
    logic [15:0] fail_ms_reg;

    // Count free-running millisecond ticks of uninterrupted link failure.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fail_ms_reg <= 16'h0000;
        end else if (keypad_link_ok) begin
            fail_ms_reg <= 16'h0000;
        end else if (ms_tick && (fail_ms_reg != 16'(KEYPAD_TIMEOUT_MS))) begin
            fail_ms_reg <= fail_ms_reg + 16'h0001;
        end
    end

    // The error stands while the link stays down past the timeout.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            keypad_comm_error <= 1'b0;
        end else begin
            keypad_comm_error <= !keypad_link_ok
                && (fail_ms_reg == 16'(KEYPAD_TIMEOUT_MS));
        end
    end

    // ------------------------------------------------------------------
    // Function selection
    // ------------------------------------------------------------------
    logic fault_hit;
    logic [4:0] oc_code;
    logic [4:0] relay_code;
    logic oc_next;
    logic relay_next;

    // Each mask bit lets one fault category through.
    assign fault_hit = (fault_condition_mask[`MFOS_MASK_UV] && uv_trip)
        || (fault_condition_mask[`MFOS_MASK_TRIP] && (ov_trip || other_trip))
        || (fault_condition_mask[`MFOS_MASK_RESTART] && restart_exhausted);

    // A code outside the range falls back to the output's default.
    assign oc_code = (open_collector_function_code > `MFOS_CODE_MAX)
        ? `MFOS_OC_CODE_DEF : open_collector_function_code;
    assign relay_code = (relay_function_code > `MFOS_CODE_MAX)
        ? `MFOS_RELAY_CODE_DEF : relay_function_code;

    // Map a function code to the drive condition it reports.
    function automatic logic pick(input logic [4:0] code);
        logic hit;
        hit = 1'b0;
        unique case (mfos_pkg::mfos_func_t'(code))
            mfos_pkg::FN_MATCH: hit = fif.match;
            mfos_pkg::FN_MATCH_LVL: hit = fif.match_at_level;
            mfos_pkg::FN_WINDOW: hit = fif.window;
            mfos_pkg::FN_HYST: hit = fif.hyst;
            mfos_pkg::FN_HYST_INV: hit = fif.hyst_inv;
            mfos_pkg::FN_MOTOR_OL: hit = motor_overload_flag;
            mfos_pkg::FN_DRIVE_OL: hit = drive_overload_flag;
            mfos_pkg::FN_STALL: hit = stall_flag;
            mfos_pkg::FN_OV: hit = ov_trip;
            mfos_pkg::FN_UV: hit = uv_trip;
            mfos_pkg::FN_OVERHEAT: hit = heatsink_overheat_flag;
            mfos_pkg::FN_CMD_LOSS: hit = analog_ref_lost || rs485_cmd_lost;
            mfos_pkg::FN_RUN: hit = run_cmd && output_active;
            mfos_pkg::FN_STOP: hit = !output_active && !run_cmd;
            mfos_pkg::FN_CONST: hit = output_active && !accel && !decel;
            mfos_pkg::FN_SEARCH: hit = speed_search_flag;
            mfos_pkg::FN_WAIT_RUN: hit = run_wait && !run_cmd;
            mfos_pkg::FN_FAULT: hit = fault_hit;
            mfos_pkg::FN_FAN: hit = fan_trip_alarm && (fan_trip_handling == 2'h0);
            mfos_pkg::FN_BRAKE: hit = brake_signal && brake_enable;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // The keypad error is merged into whichever outputs the routing names.
    always_comb begin
        oc_next = pick(oc_code)
            || (keypad_error_routing[`MFOS_ROUTE_OC] && keypad_comm_error);
        relay_next = pick(relay_code)
            || (keypad_error_routing[`MFOS_ROUTE_RELAY] && keypad_comm_error);
    end

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    // Both outputs are refreshed together on every control sample.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            open_collector_output <= 1'b0;
            relay_contact_output <= 1'b0;
        end else if (sample_tick) begin
            open_collector_output <= oc_next;
            relay_contact_output <= relay_next;
        end
    end

    // The transistor only ever pulls low; enable is low while it conducts.
    assign open_collector_pin_out = 1'b0;
    assign open_collector_pin_oe_b = !open_collector_output;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_oc_run;
        sample_tick && (oc_code == 5'h0c) && run_cmd && output_active;
    endsequence
    sequence s_relay_uv_masked;
        sample_tick && (relay_code == 5'h11) && uv_trip && fault_condition_mask[0];
    endsequence
    sequence s_fan_blocked;
        sample_tick && (relay_code == 5'h12) && (fan_trip_handling != 2'h0)
            && !keypad_error_routing[1];
    endsequence

    AST_OC_RUN: assert property (@(posedge clk) disable iff (!rst_b)
        s_oc_run |=> open_collector_output && !open_collector_pin_oe_b)
        else $error("Open collector missed the running state.");
    AST_RELAY_UV: assert property (@(posedge clk) disable iff (!rst_b)
        s_relay_uv_masked |=> relay_contact_output)
        else $error("Relay missed a masked undervoltage fault.");
    AST_FAN_GATE: assert property (@(posedge clk) disable iff (!rst_b)
        s_fan_blocked |=> !relay_contact_output)
        else $error("Fan alarm passed while fan trip handling was not zero.");
    AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        !sample_tick |=> $stable(open_collector_output) && $stable(relay_contact_output))
        else $error("An output changed between control samples.");
    AST_SAMPLE_GAP: assert property (@(posedge clk) disable iff (!rst_b)
        sample_tick |=> !sample_tick [*8])
        else $error("Control samples came too close together.");
    AST_LEVEL_CAP: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> (level_applied <= 16'h9c40) && (bandwidth_applied <= 16'h9c40)
            && (level_applied <= $past(max_frequency_limit)))
        else $error("Applied detection setting exceeds its ceiling.");
    AST_OV_200: assert property (@(posedge clk) disable iff (!rst_b)
        !class_400v && (dc_link_volts == 10'h191) |=> ov_trip)
        else $error("Overvoltage trip missed just above 400 volts.");
    AST_UV_400: assert property (@(posedge clk) disable iff (!rst_b)
        class_400v && (dc_link_volts == 10'h168) |=> !uv_trip)
        else $error("Undervoltage trip raised at exactly 360 volts.");
    AST_KEYPAD_TIME: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(keypad_comm_error) |-> $past(fail_ms_reg) == 16'(KEYPAD_TIMEOUT_MS))
        else $error("Keypad error raised before the timeout.");
    AST_KEYPAD_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
        keypad_link_ok |=> !keypad_comm_error)
        else $error("Keypad error stayed with the link healthy.");
    AST_KEYPAD_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)
        sample_tick && keypad_comm_error && keypad_error_routing[0] |=> open_collector_output)
        else $error("Keypad error not routed to the open collector.");

    // Per-code checks on the selected outputs, each at a sample tick, and one unsampled overvoltage check on the 400 V class at 820 volts.
    AST_CMD_LOSS: assert property (@(posedge clk) disable iff (!rst_b)
        sample_tick && (oc_code == 5'h0b) && (analog_ref_lost || rs485_cmd_lost)
            |=> open_collector_output)
        else $error("Open collector missed a command loss.");
    AST_STOP: assert property (@(posedge clk) disable iff (!rst_b)
        sample_tick && (relay_code == 5'h0d) && !run_cmd && !output_active
            |=> relay_contact_output)
        else $error("Relay missed the stopped state.");
    AST_CONST_ACCEL: assert property (@(posedge clk) disable iff (!rst_b)
        sample_tick && (oc_code == 5'h0e) && accel && !keypad_error_routing[0]
            |=> !open_collector_output)
        else $error("Constant speed reported while accelerating.");
    AST_WAIT_RUN: assert property (@(posedge clk) disable iff (!rst_b)
        sample_tick && (relay_code == 5'h10) && run_cmd && !keypad_error_routing[1]
            |=> !relay_contact_output)
        else $error("Run wait reported with a run command present.");
    AST_BRAKE_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        sample_tick && (oc_code == 5'h13) && !brake_enable && !keypad_error_routing[0]
            |=> !open_collector_output)
        else $error("Brake signal passed while brake control was disabled.");
    AST_HEAT: assert property (@(posedge clk) disable iff (!rst_b)
        sample_tick && (relay_code == 5'h0a) && heatsink_overheat_flag
            |=> relay_contact_output)
        else $error("Relay missed a heatsink overheat.");
    AST_CODE_DEFAULT: assert property (@(posedge clk) disable iff (!rst_b)
        sample_tick && (open_collector_function_code > 5'h13) && run_cmd && output_active
            |=> open_collector_output)
        else $error("Out of range code did not fall back to the running state.");
    AST_MASK_NONE: assert property (@(posedge clk) disable iff (!rst_b)
        sample_tick && (relay_code == 5'h11) && (fault_condition_mask == 3'h0)
            && !keypad_error_routing[1] |=> !relay_contact_output)
        else $error("Fault output raised with an empty mask.");
    AST_FAULT_TRIP: assert property (@(posedge clk) disable iff (!rst_b)
        sample_tick && (relay_code == 5'h11) && fault_condition_mask[1] && other_trip
            |=> relay_contact_output)
        else $error("Relay missed a masked trip.");
    AST_OV_400: assert property (@(posedge clk) disable iff (!rst_b)
        class_400v && (dc_link_volts == 10'h334) |=> !ov_trip)
        else $error("Overvoltage trip raised at exactly 820 volts.");
    AST_WINDOW_OC: assert property (@(posedge clk) disable iff (!rst_b)
        sample_tick && (oc_code == 5'h02) && fif.window |=> open_collector_output)
        else $error("Open collector missed the level window.");
endmodule // mfos_top
`default_nettype wire

// >>> tb/mfos_ext_model.sv
// Model of the line wired to the selector's open collector output.
`timescale 1ns/1ps
`default_nettype none
module mfos_ext_model (
    // Selector side.
    input wire logic pin_out,
    input wire logic pin_oe_b,
    // Pin seen by the sequence controller.
    output logic pin_level
);
    // The line has a pull-up, so a released transistor reads high.
    assign pin_level = pin_oe_b ? 1'b1 : pin_out;
endmodule // mfos_ext_model
`default_nettype wire

// >>> tb/test_mfos_top.sv
// Self-checking bench for the multifunction output selector.
`timescale 1ns/1ps
`default_nettype none
module test_mfos_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hy = 1'b0;
    logic [15:0] cmd = '0, run = '0, lvl = '0, bw = '0, rs = 16'h0014;
    logic [15:0] mx = 16'hffff;
    logic [4:0] occ = '0, rcc = '0;
    logic [2:0] msk = '0;
    logic [1:0] route = '0, fan = '0;
    logic [9:0] volts = '0;
    logic [18:0] b = '0;
    logic oc, pin_out, oe_b, rly, kerr, ov, uv, pin_level;
    logic [15:0] lvl_app, bw_app;
    int n_errors = 0;
    int checks = 0;
    mfos_top #(.MS_TICK_CYCLES(10), .KEYPAD_TIMEOUT_MS(3)) i_mfos_top (.clk, .rst_b,
        .freq_cmd(cmd), .freq_run(run), .freq_detect_level(lvl), .freq_detect_bandwidth(bw),
        .max_frequency_limit(mx), .open_collector_function_code(occ),
        .relay_function_code(rcc), .fault_condition_mask(msk), .keypad_error_routing(route),
        .fan_trip_handling(fan), .brake_enable(b[0]), .run_cmd(b[1]), .output_active(b[2]),
        .accel(b[3]), .decel(b[4]), .run_wait(b[5]), .dc_link_volts(volts), .class_400v(b[6]),
        .motor_overload_flag(b[7]), .drive_overload_flag(b[8]), .stall_flag(b[9]),
        .speed_search_flag(b[10]), .heatsink_overheat_flag(b[11]), .analog_ref_lost(b[12]),
        .rs485_cmd_lost(b[13]), .other_trip(b[14]), .restart_exhausted(b[15]),
        .fan_trip_alarm(b[16]), .brake_signal(b[17]), .keypad_link_ok(b[18]),
        .open_collector_output(oc), .open_collector_pin_out(pin_out),
        .open_collector_pin_oe_b(oe_b), .relay_contact_output(rly), .keypad_comm_error(kerr),
        .ov_trip(ov), .uv_trip(uv), .level_applied(lvl_app), .bandwidth_applied(bw_app));
    mfos_ext_model i_mfos_ext_model (.pin_out(pin_out), .pin_oe_b(oe_b),
        .pin_level(pin_level));
    // Clock of 8 ns period.
    always #4 clk = ~clk;
    // Next value of the pseudo-random sequence.
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // Compares one result and counts the outcome.
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Works out every selectable condition and compares both outputs.
    task automatic check();
        int c, r, l, h, v, m, hw;
        logic [19:0] f;
        logic o, y, ke, ove, uve;
        c = cmd;
        r = run;
        m = mx > 40000 ? 40000 : mx;
        l = lvl > m ? m : lvl;
        hw = bw > m ? m : bw;
        h = hw / 2;
        v = volts;
        ove = b[6] ? v > 820 : v > 400;
        uve = b[6] ? v < 360 : v < 180;
        ke = !b[18];
        f[0] = (c > r ? c - r : r - c) <= h;
        f[1] = f[0] && c == l;
        f[2] = (l > r ? l - r : r - l) <= h;
        f[3] = hy;
        f[4] = !hy;
        f[9:5] = {uve, ove, b[9], b[8], b[7]};
        f[11:10] = {b[12] | b[13], b[11]};
        f[12] = b[1] & b[2];
        f[13] = !b[1] & !b[2];
        f[14] = b[2] & !b[3] & !b[4];
        f[16:15] = {b[5] & !b[1], b[10]};
        f[17] = (msk[0] & uve) | (msk[1] & (ove | b[14])) | (msk[2] & b[15]);
        f[18] = b[16] && fan == 2'h0;
        f[19] = b[0] & b[17];
        o = f[occ > 5'h13 ? 5'h0c : occ] | (ke & route[0]);
        y = f[rcc > 5'h13 ? 5'h11 : rcc] | (ke & route[1]);
        cmp(16'(oc), 16'(o));
        cmp(16'(rly), 16'(y));
        cmp(16'(pin_level), 16'(!o));
        cmp(16'(kerr), 16'(ke));
        cmp({ov, uv}, {ove, uve});
        cmp(lvl_app, 16'(l));
        cmp(bw_app, 16'(hw));
    endtask
    // Main sequence: reset values, then 72 random settings, each held for 400 clocks (three or four sample ticks).
    initial begin
        int l, w, d, m, lc, wc;
        int bnd[4] = '{180, 360, 400, 820};
        logic [15:0] t;
        repeat (2) @(posedge clk);
        #1;
        cmp({oc, rly, oe_b, kerr}, 16'h0002);
        cmp(lvl_app, 16'h0bb8);
        cmp(bw_app, 16'h03e8);
        rst_b <= 1'b1;
        for (int i = 0; i < 72; i++) begin
            @(posedge clk);
            rs = lfsr(rs);
            l = 2000 + rs % 2000;
            rs = lfsr(rs);
            w = 2 * (rs % 600);
            rs = lfsr(rs);
            d = l + rs % 1200 - 600;
            m = rs[14] ? 65535 : rs[15:4];
            lc = l > m ? m : l;
            wc = w > m ? m : w;
            lvl <= 16'(l);
            bw <= 16'(w);
            run <= 16'(d);
            mx <= 16'(m);
            cmd <= rs[0] ? 16'(l) : 16'(d + rs[9:1] % 400 - 200);
            volts <= i[0] ? 10'(bnd[(i / 2) % 4] + (i / 8) % 3 - 1) : 10'(lfsr(rs));
            rs = lfsr(lfsr(rs));
            t = lfsr(rs);
            b <= {rs[1:0] != 2'h0, rs[12:0], t[4:0]};
            occ <= 5'(i % 24);
            rcc <= 5'((i * 7) % 24);
            msk <= rs[15:13];
            route <= rs[3:2];
            fan <= rs[5:4];
            #1;
            if (b[3]) hy = d >= lc;
            else if (b[4]) hy = d > (lc - wc / 2 < 0 ? 0 : lc - wc / 2);
            repeat (400) @(posedge clk);
            #1;
            check();
        end
        end_sim();
    end
    // Cuts a hung run short.
    initial begin
        #700000;
        n_errors++;
        end_sim();
    end
endmodule // test_mfos_top
`default_nettype wire
